// file: include/dbg_csr_map.vh
// debug control/status register: field positions, reset values, cause codes
// assumes inclusion by the register module and its cause picker only
`ifndef DBG_CSR_MAP_VH
`define DBG_CSR_MAP_VH

`define DCS_GLOBAL_EN_BIT 31
`define DCS_HALT_BIT 30
`define DCS_TRAP_FIQ_BIT 23
`define DCS_TRAP_IRQ_BIT 22
`define DCS_TRAP_DABT_BIT 20
`define DCS_TRAP_PABT_BIT 19
`define DCS_TRAP_SWI_BIT 18
`define DCS_TRAP_UND_BIT 17
`define DCS_TRAP_RST_BIT 16
`define DCS_STICKY_BIT 5
`define DCS_MOE_HI 4
`define DCS_MOE_LO 2
`define DCS_MODE_BIT 1
`define DCS_EN_BIT 0

`define DCS_ZERO32 32'h00000000
`define DCS_CAUSE_RESET 3'h0
`define DCS_CAUSE_IBKPT 3'h1
`define DCS_CAUSE_DBKPT 3'h2
`define DCS_CAUSE_BRK_INSN 3'h3
`define DCS_CAUSE_EXT 3'h4
`define DCS_CAUSE_VTRAP 3'h5
`define DCS_CAUSE_TBFULL 3'h6

`endif

// file: verilog/dbg_cause_pick.v
// priority picker for the debug entry cause
// assumes one-cycle event pulses already qualified by the caller
`timescale 1ns/1ps
`include "dbg_csr_map.vh"

module dbg_cause_pick (
  input wire CLK,
  input wire RSTN,
  input wire vtrap,
  input wire dbkpt,
  input wire ext_brk,
  input wire tb_full,
  input wire ibkpt,
  input wire brk_insn,
  output reg any_r,
  output reg [2:0] cause_r
);
  reg [2:0] cause_nxt;
  wire any_nxt;

  assign any_nxt = vtrap | dbkpt | ext_brk | tb_full | ibkpt | brk_insn;

  // ===========================================
  // priority: vector trap, data breakpoint_instruction, ext/tbfull, instr breakpoint_instruction, break insn
  always @* begin
    if (vtrap) begin
      cause_nxt = `DCS_CAUSE_VTRAP;
    end else if (dbkpt) begin
      cause_nxt = `DCS_CAUSE_DBKPT;
    end else if (ext_brk) begin
      cause_nxt = `DCS_CAUSE_EXT;
    end else if (tb_full) begin
      cause_nxt = `DCS_CAUSE_TBFULL;
    end else if (ibkpt) begin
      cause_nxt = `DCS_CAUSE_IBKPT;
    end else begin
      cause_nxt = `DCS_CAUSE_BRK_INSN;
    end
  end

  always @(posedge CLK) begin
    if (!RSTN) begin
      any_r <= 1'b0;
      cause_r <= `DCS_CAUSE_RESET;
    end else begin
      any_r <= any_nxt;
      cause_r <= cause_nxt;
    end
  end
endmodule

// file: verilog/dbg_ctrl_status.v
// debug control and status register with event qualification
// assumes core events are on CLK; TRST_N and JTAG strobes are async and synced
`timescale 1ns/1ps
`include "dbg_csr_map.vh"

module dbg_ctrl_status (
  // clock and reset
  input wire CLK,
  input wire RSTN,
  input wire TRST_N,
  // core software access
  input wire SW_WR,
  input wire [31:0] SW_WDATA,
  output reg [31:0] SW_RDATA,
  // jtag access (jtag domain, toggle strobe)
  input wire JTAG_WR_TGL,
  input wire [31:0] JTAG_WDATA,
  output reg [31:0] JTAG_RDATA,
  // core state
  input wire SPECIAL_DEBUG,
  input wire DATA_ABORT,
  // raw debug events
  input wire IBKPT_HIT,
  input wire DBKPT_HIT,
  input wire BRK_INSN,
  input wire EXT_BREAK,
  input wire [6:0] VECTOR_HIT,
  input wire TB_FULL,
  // results
  output reg DEBUG_EXC,
  output reg [2:0] DEBUG_CAUSE,
  output reg HALT_MODE,
  output reg TRACE_RUN,
  output reg TRACE_FILL_ONCE,
  output reg BRK_AS_NOP,
  output reg ABORT_SUPPRESS
);
  // ===========================================
  // state
  reg glob_en_r, halt_r, sticky_r, mode_r, en_r;
  reg [6:0] trap_r;
  reg [2:0] moe_r;
  reg [2:0] trst_s_r;
  reg [2:0] jwr_s_r;
  reg rst_pend_r;
  wire trst_sync_n, jwr_pulse;
  wire any_exc;
  wire [2:0] cause;
  wire glob_en_eff, vtrap_q, dbk_q, ext_q, tbf_q, ibk_q, bki_q, sticky_set;

  // trst and the jtag strobe come from another domain: two flops before use
  always @(posedge CLK) begin
    trst_s_r <= {trst_s_r[1:0], TRST_N};
    jwr_s_r <= {jwr_s_r[1:0], JTAG_WR_TGL};
  end
  assign trst_sync_n = trst_s_r[1];
  assign jwr_pulse = jwr_s_r[2] ^ jwr_s_r[1];

  // ===========================================
  // event qualification
  assign glob_en_eff = glob_en_r;
  // non-reset traps need enable and halt; monitor mode ignores them
  assign vtrap_q = (glob_en_eff & halt_r & |(VECTOR_HIT[6:1] & trap_r[6:1])) |
                   (halt_r & trap_r[0] & (VECTOR_HIT[0] | rst_pend_r));
  assign dbk_q = glob_en_eff & DBKPT_HIT;
  assign ext_q = glob_en_eff & EXT_BREAK;
  assign tbf_q = glob_en_eff & en_r & mode_r & TB_FULL;
  assign ibk_q = glob_en_eff & IBKPT_HIT;
  assign bki_q = glob_en_eff & BRK_INSN;
  assign sticky_set = halt_r & SPECIAL_DEBUG & DATA_ABORT;

  dbg_cause_pick u_pick (
    .CLK(CLK),
    .RSTN(RSTN),
    .vtrap(vtrap_q),
    .dbkpt(dbk_q),
    .ext_brk(ext_q),
    .tb_full(tbf_q),
    .ibkpt(ibk_q),
    .brk_insn(bki_q),
    .any_r(any_exc),
    .cause_r(cause)
  );

  // ===========================================
  // reset-trap pending: fires once on the first cycle after reset release
  always @(posedge CLK) begin
    if (!RSTN) begin
      rst_pend_r <= 1'b1;
    end else begin
      rst_pend_r <= 1'b0;
    end
  end

  // ===========================================
  // software-owned fields; processor reset clears, trst leaves alone
  always @(posedge CLK) begin
    if (!RSTN) begin
      glob_en_r <= 1'b0;
      sticky_r <= 1'b0;
      moe_r <= `DCS_CAUSE_RESET;
      mode_r <= 1'b0;
      en_r <= 1'b0;
    end else begin
      if (SW_WR) begin
        glob_en_r <= SW_WDATA[`DCS_GLOBAL_EN_BIT];
        mode_r <= SW_WDATA[`DCS_MODE_BIT];
        moe_r <= SW_WDATA[`DCS_MOE_HI:`DCS_MOE_LO];
      end
      // sticky set wins over a software clear in the same cycle
      if (sticky_set) begin
        sticky_r <= 1'b1;
      end else if (SW_WR) begin
        sticky_r <= SW_WDATA[`DCS_STICKY_BIT];
      end
      // hardware clear on an exception beats a software set
      if (any_exc) begin
        en_r <= 1'b0;
        moe_r <= cause;
      end else if (SW_WR) begin
        en_r <= SW_WDATA[`DCS_EN_BIT];
      end
    end
  end

  // ===========================================
  // jtag-owned fields; survive processor reset, cleared by trst
  always @(posedge CLK) begin
    if (!trst_sync_n) begin
      halt_r <= 1'b0;
      trap_r <= 7'h00;
    end else if (jwr_pulse) begin
      halt_r <= JTAG_WDATA[`DCS_HALT_BIT];
      trap_r <= {JTAG_WDATA[`DCS_TRAP_FIQ_BIT], JTAG_WDATA[`DCS_TRAP_IRQ_BIT],
                 JTAG_WDATA[`DCS_TRAP_DABT_BIT], JTAG_WDATA[`DCS_TRAP_PABT_BIT],
                 JTAG_WDATA[`DCS_TRAP_SWI_BIT], JTAG_WDATA[`DCS_TRAP_UND_BIT],
                 JTAG_WDATA[`DCS_TRAP_RST_BIT]};
    end
  end

  // ===========================================
  // read image and registered outputs
  reg [31:0] image;
  always @* begin
    image = `DCS_ZERO32;
    image[`DCS_GLOBAL_EN_BIT] = glob_en_r;
    image[`DCS_HALT_BIT] = halt_r;
    image[`DCS_TRAP_FIQ_BIT] = trap_r[6];
    image[`DCS_TRAP_IRQ_BIT] = trap_r[5];
    image[`DCS_TRAP_DABT_BIT] = trap_r[4];
    image[`DCS_TRAP_PABT_BIT] = trap_r[3];
    image[`DCS_TRAP_SWI_BIT] = trap_r[2];
    image[`DCS_TRAP_UND_BIT] = trap_r[1];
    image[`DCS_TRAP_RST_BIT] = trap_r[0];
    image[`DCS_STICKY_BIT] = sticky_r;
    image[`DCS_MOE_HI:`DCS_MOE_LO] = moe_r;
    image[`DCS_MODE_BIT] = mode_r;
    image[`DCS_EN_BIT] = en_r;
  end

  always @(posedge CLK) begin
    if (!RSTN) begin
      SW_RDATA <= `DCS_ZERO32;
      JTAG_RDATA <= `DCS_ZERO32;
      DEBUG_EXC <= 1'b0;
      DEBUG_CAUSE <= `DCS_CAUSE_RESET;
      HALT_MODE <= 1'b0;
      TRACE_RUN <= 1'b0;
      TRACE_FILL_ONCE <= 1'b0;
      BRK_AS_NOP <= 1'b1;
      ABORT_SUPPRESS <= 1'b0;
    end else begin
      SW_RDATA <= image;
      JTAG_RDATA <= image;
      DEBUG_EXC <= any_exc;
      DEBUG_CAUSE <= cause;
      HALT_MODE <= halt_r;
      TRACE_RUN <= en_r & glob_en_r & ~any_exc;
      TRACE_FILL_ONCE <= mode_r;
      BRK_AS_NOP <= ~glob_en_r;
      ABORT_SUPPRESS <= halt_r & SPECIAL_DEBUG;
    end
  end
endmodule

// file: bench/dbg_ctrl_status_sva.sv
// port checker for the debug control/status register
// assumes it is bound onto dbg_ctrl_status
`timescale 1ns/1ps
module dbg_ctrl_status_sva (
  // clock, reset, core inputs
  input wire CLK, input wire RSTN, input wire SPECIAL_DEBUG,
  input wire IBKPT_HIT, input wire DBKPT_HIT, input wire BRK_INSN,
  input wire EXT_BREAK, input wire TB_FULL,
  // register images and results
  input wire [31:0] SW_RDATA, input wire [31:0] JTAG_RDATA,
  input wire DEBUG_EXC, input wire [2:0] DEBUG_CAUSE, input wire HALT_MODE,
  input wire TRACE_RUN, input wire BRK_AS_NOP, input wire ABORT_SUPPRESS
);
  // ====================
  // assertions
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  nop_flag_a: assert property (BRK_AS_NOP == !SW_RDATA[31])
    else $error("nop flag disagrees with enable");
  rsvd_zero_a: assert property ((SW_RDATA & 32'h3F20FFC0) == 32'h0)
    else $error("reserved bits read nonzero");
  image_same_a: assert property (JTAG_RDATA == SW_RDATA)
    else $error("jtag image differs");
  halt_out_a: assert property (HALT_MODE == SW_RDATA[30])
    else $error("halt output differs from bit");
  trace_gate_a: assert property (TRACE_RUN |-> SW_RDATA[0] && SW_RDATA[31])
    else $error("trace runs without enables");
  // the register image trails the exception pulse by one cycle
  exc_fields_a: assert property (DEBUG_EXC |-> !TRACE_RUN ##1 !SW_RDATA[0]
    && SW_RDATA[4:2] == $past(DEBUG_CAUSE)) else $error("exception fields wrong");
  dbk_fires_a: assert property (DBKPT_HIT && SW_RDATA[31] && $past(SW_RDATA[31])
    && !SPECIAL_DEBUG |-> ##2 DEBUG_EXC) else $error("data breakpoint lost");
  gate_off_a: assert property ((IBKPT_HIT || DBKPT_HIT || EXT_BREAK || BRK_INSN
    || TB_FULL) && BRK_AS_NOP && $past(BRK_AS_NOP) |-> ##2 !DEBUG_EXC)
    else $error("event not gated");
  abort_halt_a: assert property (ABORT_SUPPRESS |-> HALT_MODE)
    else $error("abort suppressed outside halt");
endmodule
bind dbg_ctrl_status dbg_ctrl_status_sva i_chk (.*);

// file: bench/jtag_host_model.sv
// external debugger model: jtag writes and jtag reset
// assumes the core clock only paces the model
`timescale 1ns/1ps
module jtag_host_model (
  input wire CLK,
  output logic TRST_N,
  output logic WR_TGL,
  output logic [31:0] WDATA
);
  initial begin
    TRST_N = 1'b0;
    WR_TGL = 1'b0;
    WDATA = 32'h00000000;
  end
  // data held past the synced landing; six cycles keeps writes apart
  task automatic jwrite(input logic [31:0] d);
    @(negedge CLK);
    WDATA = d;
    WR_TGL = ~WR_TGL;
    repeat (6) @(negedge CLK);
  endtask
  task automatic jreset();
    @(negedge CLK);
    TRST_N = 1'b0;
    repeat (4) @(negedge CLK);
    TRST_N = 1'b1;
    repeat (4) @(negedge CLK);
  endtask
endmodule

// file: bench/debug_control_status_logic_tb.sv
// self-checking bench for the debug control/status register
// assumes the jtag model and the bound checker
`timescale 1ns/1ps
module debug_control_status_logic_tb;
  logic CLK = 1'b0, RSTN = 1'b0, SW_WR = 1'b0, SPECIAL_DEBUG = 1'b0, DATA_ABORT = 1'b0;
  logic [31:0] SW_WDATA = 32'h00000000;
  logic [5:0] ev = 6'h00;
  wire TRST_N, JTAG_WR_TGL, DEBUG_EXC, HALT_MODE, TRACE_RUN, TRACE_FILL_ONCE;
  wire BRK_AS_NOP, ABORT_SUPPRESS;
  wire [31:0] JTAG_WDATA, SW_RDATA, JTAG_RDATA;
  wire [2:0] DEBUG_CAUSE;
  int fail_count = 0, num_checks = 0, cyc = 0;
  // event bits: ibkpt, dbkpt, break insn, ext, fiq vector, trace full
  dbg_ctrl_status i_dut (.*, .IBKPT_HIT(ev[0]), .DBKPT_HIT(ev[1]), .BRK_INSN(ev[2]),
    .EXT_BREAK(ev[3]), .VECTOR_HIT({ev[4], 6'h00}), .TB_FULL(ev[5]));
  jtag_host_model i_jtag (.CLK(CLK), .TRST_N(TRST_N), .WR_TGL(JTAG_WR_TGL),
    .WDATA(JTAG_WDATA));
  initial forever #5 CLK = ~CLK;
  // ====================
  // helpers
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      results();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic sw(input logic [31:0] d);
    @(negedge CLK);
    SW_WR = 1'b1;
    SW_WDATA = d;
    @(negedge CLK);
    SW_WR = 1'b0;
    @(negedge CLK);
  endtask
  // pulse events, then watch a bounded window for one exception
  task automatic fire(input logic [5:0] e, input logic [2:0] cause, input logic hit);
    logic got;
    got = 1'b0;
    @(negedge CLK);
    ev = e;
    for (int n = 0; n < 6; n++) begin
      @(negedge CLK);
      ev = 6'h00;
      if (DEBUG_EXC === 1'b1) begin
        got = 1'b1;
        chk(32'(DEBUG_CAUSE), 32'(cause));
      end
    end
    chk(32'(got), 32'(hit));
  endtask
  // ====================
  // scenarios
  task automatic t_reset();
    chk(SW_RDATA, 32'h00000000);
    chk(32'(BRK_AS_NOP), 32'h1);
  endtask
  task automatic t_access();
    sw(32'hFFFFFFFF);
    chk(SW_RDATA, 32'h8000003F);
    i_jtag.jwrite(32'hFFFFFFFF);
    chk(JTAG_RDATA, 32'hC0DF003F);
    chk(32'({HALT_MODE, TRACE_RUN, TRACE_FILL_ONCE, BRK_AS_NOP}), 32'hE);
  endtask
  task automatic t_events();
    sw(32'h80000001);
    fire(6'h20, 3'h0, 1'b0);
    for (int i = 0; i < 6; i++) begin
      sw(32'h80000003);
      fire(6'h01 << i, 3'(i + 1), 1'b1);
      chk(32'(SW_RDATA[0]), 32'h0);
    end
    sw(32'h80000003);
    fire(6'h3F, 3'h5, 1'b1);
  endtask
  task automatic t_gate();
    sw(32'h00000003);
    fire(6'h3F, 3'h0, 1'b0);
    chk(32'({TRACE_RUN, BRK_AS_NOP}), 32'h1);
  endtask
  task automatic t_rtrap();
    @(negedge CLK);
    RSTN = 1'b0;
    repeat (2) @(negedge CLK);
    RSTN = 1'b1;
    fire(6'h00, 3'h5, 1'b1);
    chk(SW_RDATA, 32'h40DF0014);
  endtask
  task automatic t_sticky();
    sw(32'h80000000);
    SPECIAL_DEBUG = 1'b1;
    DATA_ABORT = 1'b1;
    @(negedge CLK);
    DATA_ABORT = 1'b0;
    @(negedge CLK);
    chk(32'({ABORT_SUPPRESS, SW_RDATA[5]}), 32'h3);
    sw(32'h80000000);
    chk(32'(SW_RDATA[5]), 32'h0);
    SPECIAL_DEBUG = 1'b0;
  endtask
  task automatic t_trst();
    i_jtag.jwrite(32'h40000000);
    chk(SW_RDATA, 32'hC0000000);
    fire(6'h10, 3'h0, 1'b0);
    i_jtag.jreset();
    chk(SW_RDATA, 32'h80000000);
  endtask
  initial begin
    repeat (4) @(negedge CLK);
    RSTN = 1'b1;
    i_jtag.jreset();
    t_reset();
    t_access();
    t_events();
    t_gate();
    t_rtrap();
    t_sticky();
    t_trst();
    results();
  end
endmodule
